// *** rtl/vit_pkg.sv ***
// Package for the vectored interrupt controller: offsets, resets, carriers.
package vit_pkg;
  localparam int LINES = 32;
  localparam int SLOTS = 16;
  localparam logic [11:0] OFF_NSTAT = 12'h000;
  localparam logic [11:0] OFF_FSTAT = 12'h004;
  localparam logic [11:0] OFF_RAW = 12'h008;
  localparam logic [11:0] OFF_ENABLE = 12'h00c;
  localparam logic [11:0] OFF_SELECT = 12'h010;
  localparam logic [11:0] OFF_SOFTSET = 12'h014;
  localparam logic [11:0] OFF_SOFTCLR = 12'h018;
  localparam logic [11:0] OFF_VADDR = 12'h01c;
  localparam logic [11:0] OFF_DEFVEC = 12'h020;
  localparam logic [11:0] OFF_EVSTAT = 12'h024;
  localparam logic [11:0] OFF_EVMASK = 12'h028;
  localparam logic [11:0] OFF_INSERV = 12'h02c;
  localparam logic [11:0] OFF_SLOTADDR = 12'h100;
  localparam logic [11:0] OFF_SLOTCTL = 12'h200;
  localparam int SLOT_EN_BIT = 5;
  localparam int EV_NORMAL_BIT = 0;
  localparam int EV_FAST_BIT = 1;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [5:0] RST_SLOTCTL = 6'h00;
  localparam logic [1:0] RST_EV = 2'h0;
  localparam logic [16:0] RST_INSERV = 17'h0_0000;

  // One APB request as the master presents it.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } vit_apb_req_s;

  // Slave answer.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } vit_apb_rsp_s;
endpackage

// *** rtl/vit_controller.sv ***
// Vectored interrupt controller with APB register port.
// How it works
// - Request lines are active-high levels; no edge detection is done.
// - Request lines pass two flip-flops before any logic uses them.
// - Thirty-two request lines, each a bit position in every line register.
// - Sixteen vector slots, each with its own routine address.
// - A slot only counts lines routed normal, so it drives only irq.
// - Fast requests, then vectored normal, then non-vectored normal.
// - Slot 0 has highest priority, slot 15 lowest.
// - Vector register returns address of highest priority requesting slot above every slot in service, else the default.
// - Reading the vector register marks the returned source in service.
// - Writing the vector register releases the source being serviced.
// - Software raises any line by writing its bit to soft set.
// - Soft request stays until a one is written to soft clear.
// - Normal status shows enabled lines requesting a normal interrupt.
// - Three separate outputs: fast request, normal request and event status.
// - Registers sit on a bus slave port with zero wait states.
`timescale 1ns/1ps
module vit_controller
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] irq_lines_in,
  input wire vit_pkg::vit_apb_req_s apb_req_in,
  output vit_pkg::vit_apb_rsp_s apb_rsp_out,
  output logic fiq_out,
  output logic irq_out,
  output logic status_irq_out
);
  import vit_pkg::*;

  logic rst_a_q;
  logic rst_n_q;
  logic [31:0] sync1_q;
  logic [31:0] sync2_q;
  logic [31:0] enable_q;
  logic [31:0] select_q;
  logic [31:0] soft_q;
  logic [31:0] defvec_q;
  logic [31:0] slot_addr_q [SLOTS];
  logic [5:0] slot_ctl_q [SLOTS];
  logic [16:0] inserv_q;
  logic [1:0] ev_q;
  logic [1:0] evmask_q;
  logic fiq_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic [5:0] claim_q;
  logic [31:0] evread_q;
  logic [31:0] active;
  logic [31:0] normal_req;
  logic [31:0] fast_req;
  logic [31:0] covered;
  logic [15:0] slot_pend;
  logic [15:0] elig;
  logic nonvec_pend;
  logic [4:0] top;
  logic [4:0] lvl;
  logic setup;
  logic access;
  logic wr;
  logic [11:0] addr;
  logic slot_hit_a;
  logic slot_hit_c;
  logic [3:0] slot_idx;
  logic mapped;
  logic [31:0] rd_word;

  // Returns {found, index} of the lowest set bit of a 16-bit vector.
  function automatic logic [4:0] first16(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = SLOTS - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // Reset is released through two flops so removal is clock aligned.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_a_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_a_q <= 1'b1;
      rst_n_q <= rst_a_q;
    end
  end

  // two-flop synchroniser
  // Lines are plain levels, so a two-flop chain per bit is enough.
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sync1_q <= RST_WORD;
      sync2_q <= RST_WORD;
    end
    else
    begin
      sync1_q <= irq_lines_in;
      sync2_q <= sync1_q;
    end
  end

  // APB decode; the slave is always ready, so access ends in one cycle.
  assign setup = apb_req_in.psel && !apb_req_in.penable;
  assign access = apb_req_in.psel && apb_req_in.penable;
  assign wr = access && apb_req_in.pwrite;
  assign addr = apb_req_in.paddr;
  assign slot_hit_a = addr[11:6] == OFF_SLOTADDR[11:6] && addr[1:0] == 2'b00;
  assign slot_hit_c = addr[11:6] == OFF_SLOTCTL[11:6] && addr[1:0] == 2'b00;
  assign slot_idx = addr[5:2];

  // enable and fast select
  // Requests are levels; a disabled line is dropped before anything else.
  assign active = (sync2_q | soft_q) & enable_q;
  assign fast_req = active & select_q;
  assign normal_req = active & ~select_q;

  // slot request match
  // Covered lines belong to an enabled slot and are not non-vectored.
  always_comb
  begin
    covered = '0;
    slot_pend = '0;
    for (int n = 0; n < SLOTS; n++)
    begin
      if (slot_ctl_q[n][SLOT_EN_BIT])
      begin
        covered[slot_ctl_q[n][4:0]] = 1'b1;
        slot_pend[n] = normal_req[slot_ctl_q[n][4:0]];
      end
    end
  end
  assign nonvec_pend = |(normal_req & ~covered);

  // slot 0 outranks slot 15
  // A slot may interrupt only above every slot already in service.
  always_comb
  begin
    elig = '0;
    for (int n = 0; n < SLOTS; n++)
    begin
      elig[n] = slot_pend[n] && !(|(inserv_q[15:0] & 16'((32'h2 << n) - 1)));
    end
  end
  assign top = first16(elig);
  assign lvl = first16(inserv_q[15:0]);

  // fixed class ordering
  // Outputs are registered so the core sees glitch-free levels.
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      fiq_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      fiq_q <= |fast_req;
      irq_q <= top[4] || (nonvec_pend && !(|inserv_q));
    end
  end
  assign fiq_out = fiq_q;
  assign irq_out = irq_q;

  // Read multiplexer, sampled in the setup cycle.
  always_comb
  begin
    rd_word = RST_WORD;
    mapped = 1'b1;
    if (slot_hit_a)
    begin
      rd_word = slot_addr_q[slot_idx];
    end
    else if (slot_hit_c)
    begin
      rd_word = {26'h0, slot_ctl_q[slot_idx]};
    end
    else
    begin
      unique case (addr)
        OFF_NSTAT: rd_word = normal_req;
        OFF_FSTAT: rd_word = fast_req;
        OFF_RAW: rd_word = sync2_q | soft_q;
        OFF_ENABLE: rd_word = enable_q;
        OFF_SELECT: rd_word = select_q;
        OFF_SOFTSET: rd_word = soft_q;
        OFF_SOFTCLR: rd_word = RST_WORD;
        OFF_VADDR: rd_word = top[4] ? slot_addr_q[top[3:0]] : defvec_q;
        OFF_DEFVEC: rd_word = defvec_q;
        OFF_EVSTAT: rd_word = {30'h0, ev_q};
        OFF_EVMASK: rd_word = {30'h0, evmask_q};
        OFF_INSERV: rd_word = {15'h0, inserv_q};
        default: mapped = 1'b0;
      endcase
    end
  end

  // zero-wait slave capture
  // Data and claim are frozen at setup so the side effect matches the data.
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      prdata_q <= RST_WORD;
      err_q <= 1'b0;
      claim_q <= 6'h00;
      evread_q <= RST_WORD;
    end
    else if (setup)
    begin
      prdata_q <= apb_req_in.pwrite ? RST_WORD : rd_word;
      err_q <= !mapped;
      claim_q <= top[4] ? {2'b10, top[3:0]}
        : {1'b0, nonvec_pend && !(|inserv_q), 4'h0};
      evread_q <= {30'h0, ev_q};
    end
  end
  assign apb_rsp_out.pready = 1'b1;
  assign apb_rsp_out.pslverr = access && err_q;
  assign apb_rsp_out.prdata = prdata_q;

  // Plain read-write control registers.
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      enable_q <= RST_WORD;
      select_q <= RST_WORD;
      defvec_q <= RST_WORD;
      evmask_q <= RST_EV;
      for (int n = 0; n < SLOTS; n++)
      begin
        slot_addr_q[n] <= RST_WORD;
        slot_ctl_q[n] <= RST_SLOTCTL;
      end
    end
    else if (wr)
    begin
      if (slot_hit_a)
      begin
        slot_addr_q[slot_idx] <= apb_req_in.pwdata;
      end
      if (slot_hit_c)
      begin
        slot_ctl_q[slot_idx] <= apb_req_in.pwdata[5:0];
      end
      if (addr == OFF_ENABLE)
      begin
        enable_q <= apb_req_in.pwdata;
      end
      if (addr == OFF_SELECT)
      begin
        select_q <= apb_req_in.pwdata;
      end
      if (addr == OFF_DEFVEC)
      begin
        defvec_q <= apb_req_in.pwdata;
      end
      if (addr == OFF_EVMASK)
      begin
        evmask_q <= apb_req_in.pwdata[1:0];
      end
    end
  end

  // software clear
  // Set wins over clear when one write touches both on the same bit.
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      soft_q <= RST_WORD;
    end
    else if (wr && addr == OFF_SOFTSET)
    begin
      soft_q <= soft_q | apb_req_in.pwdata;
    end
    else if (wr && addr == OFF_SOFTCLR)
    begin
      soft_q <= soft_q & ~apb_req_in.pwdata;
    end
  end

  // release on vector write
  // Nesting: release clears the highest-priority source in service.
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      inserv_q <= RST_INSERV;
    end
    else if (access && addr == OFF_VADDR)
    begin
      if (!apb_req_in.pwrite && |claim_q[5:4])
      begin
        inserv_q[claim_q[5] ? {1'b0, claim_q[3:0]} : 5'h10] <= 1'b1;
      end
      else if (apb_req_in.pwrite && lvl[4])
      begin
        inserv_q[lvl[3:0]] <= 1'b0;
      end
      else if (apb_req_in.pwrite)
      begin
        inserv_q[16] <= 1'b0;
      end
    end
  end

  // Sticky events on each rise of an output; a read clears what it returned.
  // A rise in the clearing cycle survives, since set is applied last.
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ev_q <= RST_EV;
    end
    else
    begin
      ev_q <= (access && !apb_req_in.pwrite && addr == OFF_EVSTAT)
        ? (ev_q & ~evread_q[1:0]) : ev_q;
      if (irq_out == 1'b0 && (top[4] || (nonvec_pend && !(|inserv_q))))
      begin
        ev_q[EV_NORMAL_BIT] <= 1'b1;
      end
      if (fiq_out == 1'b0 && |fast_req)
      begin
        ev_q[EV_FAST_BIT] <= 1'b1;
      end
    end
  end
  assign status_irq_out = |(ev_q & evmask_q);

  sequence s_vaddr_setup_rd;
    setup && !apb_req_in.pwrite && addr == OFF_VADDR;
  endsequence

  sequence s_vaddr_access_rd;
    access && !apb_req_in.pwrite && addr == OFF_VADDR;
  endsequence

  AST_SYNC_TWO: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    ##2 sync2_q == $past(irq_lines_in, 2))
    else $error("Line synchroniser latency is not two cycles.");
  AST_SLOT_IRQ: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (|elig) |=> irq_out && fiq_out == $past(|fast_req))
    else $error("Eligible slot failed to raise only the normal output.");
  AST_SLOT0_TOP: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    elig[0] |-> top == 5'h10)
    else $error("Slot 0 did not win priority.");
  AST_VEC_DATA: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    s_vaddr_setup_rd ##0 top[4] |=> prdata_q == $past(slot_addr_q[top[3:0]]))
    else $error("Vector read returned the wrong slot address.");
  AST_DEF_DATA: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    s_vaddr_setup_rd ##0 !top[4] |=> prdata_q == $past(defvec_q))
    else $error("Vector read did not return the default address.");
  AST_CLAIM: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    s_vaddr_setup_rd ##0 top[4] ##1 s_vaddr_access_rd |=> inserv_q[$past(claim_q[3:0])])
    else $error("Vector read did not mark the source in service.");
  AST_RELEASE: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    wr && addr == OFF_VADDR && |inserv_q |=>
      $countones(inserv_q) == $countones($past(inserv_q)) - 1)
    else $error("Vector write did not release one source.");
  AST_SOFT_SET: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    wr && addr == OFF_SOFTSET |=> (soft_q & $past(apb_req_in.pwdata)) == $past(apb_req_in.pwdata))
    else $error("Soft set did not raise the written lines.");
  AST_SOFT_CLR: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    wr && addr == OFF_SOFTCLR |=> (soft_q & $past(apb_req_in.pwdata)) == 32'h0000_0000)
    else $error("Soft clear left a written line pending.");
  AST_MASKED: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    enable_q == 32'h0000_0000 |=> !fiq_out && !irq_out)
    else $error("Disabled line reached status or outputs.");
endmodule

// *** verification/vit_src_model.sv ***
// Behavioural model of the peripherals driving the request lines.
`timescale 1ns/1ps
module vit_src_model
(
  input wire logic clk_in,
  input wire logic [31:0] set_in,
  input wire logic [31:0] clr_in,
  output logic [31:0] lines_out
);
  // level held until cleared
  // A source holds its line high until its routine clears it at the source.
  initial lines_out = 32'h0000_0000;
  always @(posedge clk_in)
  begin
    lines_out <= (lines_out & ~clr_in) | set_in;
  end
endmodule

// *** verification/vit_controller_tb.sv ***
// Self-checking bench for the vectored interrupt controller.
`timescale 1ns/1ps
module vit_controller_tb;
  import vit_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [31:0] set_l = 32'h0000_0000;
  logic [31:0] clr_l = 32'h0000_0000;
  logic [31:0] lines;
  vit_apb_req_s req = '0;
  vit_apb_rsp_s rsp;
  logic fiq;
  logic irq;
  logic st_irq;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int n_compared = 0;

  // Free-running bus clock, 40 ns period.
  always #20 clk_in = ~clk_in;

  vit_src_model src (.clk_in(clk_in), .set_in(set_l), .clr_in(clr_l),
    .lines_out(lines));

  vit_controller uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .irq_lines_in(lines), .apb_req_in(req), .apb_rsp_out(rsp),
    .fiq_out(fiq), .irq_out(irq), .status_irq_out(st_irq));

  // One comparison; a mismatch is reported at once.
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the answer is taken at the edge that sees pready.
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  // Register read followed by a comparison of the returned word.
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
    input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask

  // Pulse the source model's set or clear inputs for one cycle.
  task automatic src_pulse(input logic [31:0] s, input logic [31:0] c);
    @(posedge clk_in);
    set_l <= s;
    clr_l <= c;
    @(posedge clk_in);
    set_l <= 32'h0000_0000;
    clr_l <= 32'h0000_0000;
    repeat (4) @(posedge clk_in);
  endtask

  // Everything quiet after reset.
  task automatic t_reset();
    rdc(OFF_ENABLE, RST_WORD, "enable");
    rdc(OFF_NSTAT, RST_WORD, "nstat");
    chk("fiq", {31'h0, fiq}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask

  // Masking, fast routing and the event interrupt.
  task automatic t_lines();
    apb(1'b1, OFF_ENABLE, 32'h0000_0008);
    apb(1'b1, OFF_EVMASK, 32'h0000_0001);
    src_pulse(32'h0000_0018, 32'h0);
    rdc(OFF_RAW, 32'h0000_0018, "raw");
    rdc(OFF_NSTAT, 32'h0000_0008, "nstat");
    chk("irq", {31'h0, irq}, 32'h1);
    chk("fiq", {31'h0, fiq}, 32'h0);
    chk("st_irq", {31'h0, st_irq}, 32'h1);
    rdc(OFF_EVSTAT, 32'h0000_0001, "evstat");
    apb(1'b1, OFF_SELECT, 32'h0000_0008);
    repeat (4) @(posedge clk_in);
    chk("fiq", {31'h0, fiq}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
    chk("st_irq", {31'h0, st_irq}, 32'h0);
    rdc(OFF_FSTAT, 32'h0000_0008, "fstat");
    rdc(OFF_NSTAT, 32'h0000_0000, "nstat");
    rdc(OFF_EVSTAT, 32'h0000_0002, "evstat");
    apb(1'b1, OFF_SELECT, 32'h0000_0000);
    src_pulse(32'h0, 32'h0000_0018);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask

  // Two slots claimed and released in priority order, then default.
  task automatic t_vector();
    apb(1'b1, OFF_SLOTADDR, 32'h0000_1000);
    apb(1'b1, OFF_SLOTADDR + 12'h004, 32'h0000_2000);
    apb(1'b1, OFF_SLOTADDR + 12'h03c, 32'h0000_f000);
    rdc(OFF_SLOTADDR + 12'h03c, 32'h0000_f000, "slot15 addr");
    apb(1'b1, OFF_SLOTCTL, 32'h0000_0025);
    apb(1'b1, OFF_SLOTCTL + 12'h004, 32'h0000_0023);
    apb(1'b1, OFF_DEFVEC, 32'h0000_9000);
    apb(1'b1, OFF_ENABLE, 32'h0000_00a8);
    src_pulse(32'h0000_0028, 32'h0);
    rdc(OFF_VADDR, 32'h0000_1000, "vaddr slot0");
    rdc(OFF_INSERV, 32'h0000_0001, "inserv");
    chk("fiq", {31'h0, fiq}, 32'h0);
    src_pulse(32'h0, 32'h0000_0020);
    apb(1'b1, OFF_VADDR, 32'h0000_0000);
    rdc(OFF_INSERV, 32'h0000_0000, "inserv");
    rdc(OFF_VADDR, 32'h0000_2000, "vaddr slot1");
    apb(1'b1, OFF_VADDR, 32'h0000_0000);
    src_pulse(32'h0, 32'h0000_0008);
    apb(1'b1, OFF_SOFTSET, 32'h0000_0080);
    repeat (3) @(posedge clk_in);
    rdc(OFF_NSTAT, 32'h0000_0080, "soft nstat");
    rdc(OFF_SOFTSET, 32'h0000_0080, "soft state");
    rdc(OFF_VADDR, 32'h0000_9000, "vaddr default");
    rdc(OFF_INSERV, 32'h0001_0000, "inserv default");
    apb(1'b1, OFF_VADDR, 32'h0000_0000);
    rdc(OFF_NSTAT, 32'h0000_0080, "soft held");
    apb(1'b1, OFF_SOFTCLR, 32'h0000_0080);
    repeat (4) @(posedge clk_in);
    rdc(OFF_NSTAT, 32'h0000_0000, "soft cleared");
    chk("irq", {31'h0, irq}, 32'h0);
  endtask

  // An unmapped offset is refused with an error and zero data.
  task automatic t_unmapped();
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk("pslverr", {31'h0, err}, 32'h1);
    chk("prdata", rd, 32'h0000_0000);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("compared %0d wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles.
  initial
  begin
    repeat (4000) @(posedge clk_in);
    miscompares++;
    results();
  end

  // Main sequence: reset for six cycles, then the scenarios.
  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_lines();
    t_vector();
    t_unmapped();
    results();
  end
endmodule
